// ===== design/ptm_pkg.sv
// Constants, register map and field layout of the periodic timer block.
// Assumes a single 25 MHz timer clock and a plain strobe register port.
package ptm_pkg;

  localparam int CNT_W = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;

  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

  typedef enum logic [1:0] {
    PTM_MODE_COMPARE = 2'h0,
    PTM_MODE_CAPTURE = 2'h1,
    PTM_MODE_PULSE = 2'h2,
    PTM_MODE_TIMER = 2'h3
  } ptm_mode_e;

  localparam logic [1:0] IO_RISE = 2'h0;
  localparam logic [1:0] IO_FALL = 2'h1;
  localparam logic [1:0] IO_BOTH = 2'h2;
  localparam logic [1:0] IO_NONE = 2'h3;
  localparam logic [1:0] IO_PULSE = 2'h3;

  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_RISE = 2'h1;
  localparam logic [1:0] CLR_FALL = 2'h2;
  localparam logic [1:0] CLR_BOTH = 2'h3;

  localparam logic [1:0] SRC_EXT_CODE = 2'h1;

  // Register indices
  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CMPA = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CMPB = 3'h2;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 3'h3;
  localparam logic [ADDR_W-1:0] REG_COUNT = 3'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5;

  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_IO_LO = 1;
  localparam int CTRL_IO_HI = 2;
  localparam int CTRL_MODE_LO = 3;
  localparam int CTRL_MODE_HI = 4;
  localparam int CTRL_CCLR = 5;
  localparam int CTRL_OC = 6;
  localparam int CTRL_POL = 7;
  localparam int CTRL_CAPTS = 8;
  localparam int CTRL_TCLR_LO = 9;
  localparam int CTRL_TCLR_HI = 10;
  localparam int CTRL_IFS_LO = 11;
  localparam int CTRL_IFS_HI = 12;

  // Status register fields; flags A and P clear on a write of one, the level flag does not
  localparam int STAT_VLF = 0;
  localparam int STAT_FLAG_A = 1;
  localparam int STAT_FLAG_P = 2;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

endpackage

// ===== design/ptm_timer.sv
// Periodic timer: single pulse output mode and capture input mode.
// Assumes pins synchronous to clk; counter is clocked at the clk rate.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ptm_pkg::ADDR_W-1:0] addr,
  input wire logic [ptm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ptm_pkg::DATA_W-1:0] rdata,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_out,
  output logic timer_out_oe_n,
  output logic timer_irq
);

  // ==========================================================
  // Control fields
  // ==========================================================
  logic counter_run;
  logic io_control_hi;
  logic io_control_lo;
  logic mode_select_hi;
  logic mode_select_lo;
  logic counter_clear_select;
  logic output_initial_level;
  logic output_polarity;
  logic capture_source_select;
  logic [1:0] capture_clear_select;
  logic [1:0] input_source_field;
  logic [ptm_pkg::CNT_W-1:0] compare_a_value;
  logic [ptm_pkg::CNT_W-1:0] compare_b_value;
  logic [ptm_pkg::CNT_W-1:0] period_value;
  logic [ptm_pkg::CNT_W-1:0] count;
  logic valid_level_flag;
  logic flag_a;
  logic flag_p;
  logic run_prev;

  wire logic [1:0] mode_sel = {mode_select_hi, mode_select_lo};
  wire logic [1:0] io_sel = {io_control_hi, io_control_lo};
  wire logic mode_pulse = (mode_sel == ptm_pkg::PTM_MODE_PULSE);
  wire logic mode_capture = (mode_sel == ptm_pkg::PTM_MODE_CAPTURE);

  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  logic [1:0] ext_sync;
  logic [1:0] cap_sync;
  logic ext_last;
  logic cap_last;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync <= 2'h0;
      cap_sync <= 2'h0;
      ext_last <= 1'b0;
      cap_last <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], ext_clock_pin};
      cap_sync <= {cap_sync[0], capture_input_pin};
      ext_last <= ext_sync[1];
      cap_last <= cap_sync[1];
    end
  end

  wire logic ext_rise = ext_sync[1] & ~ext_last;
  // Short pulses can vanish in the synchroniser, so they may be missed
  wire logic sel_ext = capture_source_select | (input_source_field == ptm_pkg::SRC_EXT_CODE);
  wire logic src_now = sel_ext ? ext_sync[1] : cap_sync[1];
  wire logic src_last = sel_ext ? ext_last : cap_last;
  wire logic src_rise = src_now & ~src_last;
  wire logic src_fall = ~src_now & src_last;

  // ==========================================================
  // Bus decode
  // ==========================================================
  wire logic wr_ctrl = wr && (addr == ptm_pkg::REG_CTRL);
  wire logic wr_cmpa = wr && (addr == ptm_pkg::REG_CMPA);
  wire logic wr_cmpb = wr && (addr == ptm_pkg::REG_CMPB);
  wire logic wr_period = wr && (addr == ptm_pkg::REG_PERIOD);
  wire logic wr_status = wr && (addr == ptm_pkg::REG_STATUS);
  wire logic [ptm_pkg::CNT_W-1:0] wdata_cnt = wdata[ptm_pkg::CNT_W-1:0];

  // ==========================================================
  // Event decode
  // ==========================================================
  wire logic run_rise = counter_run & ~run_prev;
  wire logic match_a = mode_pulse && counter_run && !run_rise && (count == compare_a_value);
  // A zero period never matches, so the counter wraps at its maximum
  wire logic match_p = mode_capture && counter_run && !run_rise
                       && (period_value != ptm_pkg::CNT_ZERO) && (count == period_value);

  // ==========================================================
  // Capture and clear decode
  // ==========================================================
  // Decoded once so capture and counter clear share the same edge terms
  wire logic capture_active = mode_capture && counter_run;
  wire logic src_any = src_rise | src_fall;
  wire logic io_rise = (io_sel == ptm_pkg::IO_RISE);
  wire logic io_fall = (io_sel == ptm_pkg::IO_FALL);
  wire logic io_both = (io_sel == ptm_pkg::IO_BOTH);
  wire logic clr_rise = (capture_clear_select == ptm_pkg::CLR_RISE);
  wire logic clr_fall = (capture_clear_select == ptm_pkg::CLR_FALL);
  wire logic clr_both = (capture_clear_select == ptm_pkg::CLR_BOTH);

  // Capture trigger; both io bits set matches none of the terms
  wire logic cap_edge = capture_active &&
                        ((io_rise && src_rise) ||
                         (io_fall && src_fall) ||
                         (io_both && src_any));
  // Extra counter clear chosen by the clear select field
  wire logic edge_clear = capture_active &&
                          ((clr_rise && src_rise) ||
                           (clr_fall && src_fall) ||
                           (clr_both && src_any));
  // Clear field 00 sends all captures to A; otherwise a falling edge goes to B
  wire logic cap_to_b = (capture_clear_select != ptm_pkg::CLR_NONE) && src_fall;
  wire logic cap_a = cap_edge && !cap_to_b;
  wire logic cap_b = cap_edge && cap_to_b;

  // External pin edge arms the pulse in single pulse mode
  // Only an idle counter is armed, so edges during a pulse are ignored
  wire logic ext_start = mode_pulse && ext_rise && !counter_run;
  wire logic irq_event = match_a | match_p | cap_edge;

  // ==========================================================
  // Control register
  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_control_lo <= 1'b0;
      io_control_hi <= 1'b0;
      mode_select_lo <= 1'b0;
      mode_select_hi <= 1'b0;
      counter_clear_select <= 1'b0;
      output_initial_level <= 1'b0;
      output_polarity <= 1'b0;
      capture_source_select <= 1'b0;
      capture_clear_select <= 2'h0;
      input_source_field <= 2'h0;
    end else if (wr_ctrl) begin
      io_control_lo <= wdata[ptm_pkg::CTRL_IO_LO];
      io_control_hi <= wdata[ptm_pkg::CTRL_IO_HI];
      mode_select_lo <= wdata[ptm_pkg::CTRL_MODE_LO];
      mode_select_hi <= wdata[ptm_pkg::CTRL_MODE_HI];
      counter_clear_select <= wdata[ptm_pkg::CTRL_CCLR];
      output_initial_level <= wdata[ptm_pkg::CTRL_OC];
      output_polarity <= wdata[ptm_pkg::CTRL_POL];
      capture_source_select <= wdata[ptm_pkg::CTRL_CAPTS];
      capture_clear_select <= wdata[ptm_pkg::CTRL_TCLR_HI:ptm_pkg::CTRL_TCLR_LO];
      input_source_field <= wdata[ptm_pkg::CTRL_IFS_HI:ptm_pkg::CTRL_IFS_LO];
    end
  end

  // ==========================================================
  // Run bit
  // ==========================================================
  // A software write wins over the hardware stop and start in the same cycle
  logic next_counter_run;
  always_comb begin
    next_counter_run = counter_run;
    if (wr_ctrl) begin
      next_counter_run = wdata[ptm_pkg::CTRL_RUN];
    end else if (match_a) begin
      next_counter_run = 1'b0;
    end else if (ext_start) begin
      next_counter_run = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      counter_run <= 1'b0;
    end else begin
      counter_run <= next_counter_run;
    end
  end

  // ==========================================================
  // Counter
  // ==========================================================
  // The period match clears only in capture mode; counter clear select is
  // never read here, so it has no effect in either mode
  logic [ptm_pkg::CNT_W-1:0] next_count;
  always_comb begin
    next_count = count;
    if (run_rise) begin
      next_count = ptm_pkg::CNT_ZERO;
    end else if (counter_run) begin
      if (match_p || edge_clear) begin
        next_count = ptm_pkg::CNT_ZERO;
      end else if (!match_a) begin
        next_count = count + ptm_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= ptm_pkg::CNT_ZERO;
      run_prev <= 1'b0;
    end else begin
      count <= next_count;
      run_prev <= counter_run;
    end
  end

  // ==========================================================
  // Compare, capture and period registers
  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_a_value <= ptm_pkg::CNT_ZERO;
      compare_b_value <= ptm_pkg::CNT_ZERO;
      period_value <= ptm_pkg::CNT_ZERO;
    end else begin
      if (cap_a) begin
        compare_a_value <= count;
      end else if (wr_cmpa) begin
        compare_a_value <= wdata_cnt;
      end
      if (cap_b) begin
        compare_b_value <= count;
      end else if (wr_cmpb) begin
        compare_b_value <= wdata_cnt;
      end
      if (wr_period) begin
        period_value <= wdata_cnt;
      end
    end
  end

  // ==========================================================
  // Flags and interrupt request
  // ==========================================================
  // A hardware set wins over a write-one clear in the same cycle
  wire logic set_a = match_a | cap_edge;
  wire logic clr_a = wr_status & wdata[ptm_pkg::STAT_FLAG_A];
  wire logic clr_p = wr_status & wdata[ptm_pkg::STAT_FLAG_P];

  wire logic next_flag_a = set_a | (flag_a & ~clr_a);
  wire logic next_flag_p = match_p | (flag_p & ~clr_p);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end else begin
      flag_a <= next_flag_a;
      flag_p <= next_flag_p;
    end
  end

  // Interrupt is a one-cycle pulse per event; the level flag keeps the
  // selected input level seen at the last capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_level_flag <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_event;
      if (cap_edge) begin
        valid_level_flag <= src_now;
      end
    end
  end

  // ==========================================================
  // Pulse output
  // ==========================================================
  // Pulse is high while the run bit is high; initial level and polarity only
  // shape the pin in single pulse mode
  wire logic pulse_level = counter_run ^ output_initial_level ^ output_polarity;

  // Pin is driven only in single pulse mode and released in every other mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_out_oe_n <= 1'b1;
    end else begin
      timer_out_oe_n <= ~mode_pulse;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_out <= 1'b0;
    end else if (mode_pulse) begin
      timer_out <= pulse_level;
    end else begin
      timer_out <= 1'b0;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic [ptm_pkg::DATA_W-1:0] ctrl_word;
  logic [ptm_pkg::DATA_W-1:0] status_word;
  logic [ptm_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    ctrl_word = ptm_pkg::DATA_ZERO;
    ctrl_word[ptm_pkg::CTRL_RUN] = counter_run;
    ctrl_word[ptm_pkg::CTRL_IO_LO] = io_control_lo;
    ctrl_word[ptm_pkg::CTRL_IO_HI] = io_control_hi;
    ctrl_word[ptm_pkg::CTRL_MODE_LO] = mode_select_lo;
    ctrl_word[ptm_pkg::CTRL_MODE_HI] = mode_select_hi;
    ctrl_word[ptm_pkg::CTRL_CCLR] = counter_clear_select;
    ctrl_word[ptm_pkg::CTRL_OC] = output_initial_level;
    ctrl_word[ptm_pkg::CTRL_POL] = output_polarity;
    ctrl_word[ptm_pkg::CTRL_CAPTS] = capture_source_select;
    ctrl_word[ptm_pkg::CTRL_TCLR_HI:ptm_pkg::CTRL_TCLR_LO] = capture_clear_select;
    ctrl_word[ptm_pkg::CTRL_IFS_HI:ptm_pkg::CTRL_IFS_LO] = input_source_field;
    status_word = ptm_pkg::DATA_ZERO;
    status_word[ptm_pkg::STAT_VLF] = valid_level_flag;
    status_word[ptm_pkg::STAT_FLAG_A] = flag_a;
    status_word[ptm_pkg::STAT_FLAG_P] = flag_p;
    next_rdata = ptm_pkg::DATA_ZERO;
    if (addr == ptm_pkg::REG_CTRL) begin
      next_rdata = ctrl_word;
    end else if (addr == ptm_pkg::REG_CMPA) begin
      next_rdata[ptm_pkg::CNT_W-1:0] = compare_a_value;
    end else if (addr == ptm_pkg::REG_CMPB) begin
      next_rdata[ptm_pkg::CNT_W-1:0] = compare_b_value;
    end else if (addr == ptm_pkg::REG_PERIOD) begin
      next_rdata[ptm_pkg::CNT_W-1:0] = period_value;
    end else if (addr == ptm_pkg::REG_COUNT) begin
      next_rdata[ptm_pkg::CNT_W-1:0] = count;
    end else if (addr == ptm_pkg::REG_STATUS) begin
      next_rdata = status_word;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= ptm_pkg::DATA_ZERO;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= ptm_pkg::DATA_ZERO;
    end
  end

endmodule
`default_nettype wire

// ===== dv/ptm_timer_checker.sv
// Port-level assertions for the periodic timer.
// Assumes software writes the control word whole; tracks it in a shadow copy.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ptm_pkg::ADDR_W-1:0] addr,
  input wire logic [ptm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [ptm_pkg::DATA_W-1:0] rdata,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  input wire logic timer_out,
  input wire logic timer_out_oe_n,
  input wire logic timer_irq
);
  // ==========
  // Shadow of software settings
  logic [15:0] ctl;
  logic [9:0] cmpa;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl <= 16'h0000;
      cmpa <= 10'h000;
    end else if (wr && addr == ptm_pkg::REG_CTRL) begin
      ctl <= wdata;
    end else if (wr && addr == ptm_pkg::REG_CMPA) begin
      cmpa <= wdata[9:0];
    end
  end
  wire logic pulse_cfg = ctl[4:3] == ptm_pkg::PTM_MODE_PULSE && ctl[2:0] == 3'h6 && ctl[7:6] == 2'h0;
  wire logic cap_cfg = ctl[4:3] == ptm_pkg::PTM_MODE_CAPTURE;
  wire logic pin_src = !ctl[8] && ctl[12:11] != ptm_pkg::SRC_EXT_CODE;
  wire logic sw_stop = wr && addr == ptm_pkg::REG_CTRL && wdata[7:6] == 2'h0 && wdata[4:0] == 5'h16;
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_ext_rise;
    pulse_cfg && cmpa > 10'h004 && !timer_out && $rose(ext_clock_pin) ##1 ext_clock_pin;
  endsequence
  sequence s_cap_rise;
    cap_cfg && pin_src && ctl[2:0] == 3'h1 && $rose(capture_input_pin) ##1 capture_input_pin;
  endsequence
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == ptm_pkg::DATA_ZERO)
    else $error("read data not zero outside read slot");
  AST_RD_WIDTH: assert property ($past(rd) && $past(addr) inside {[3'h1:3'h4]} |-> rdata[15:10] == 6'h00)
    else $error("upper bits of a ten bit register not zero");
  AST_OE_ON: assert property (pulse_cfg [*3] |-> !timer_out_oe_n)
    else $error("output not driven in pulse mode");
  AST_OE_OFF: assert property ((ctl[4:3] != ptm_pkg::PTM_MODE_PULSE) [*3] |-> timer_out_oe_n)
    else $error("output driven outside pulse mode");
  AST_PULSE_STOP: assert property ((!ext_clock_pin) [*6] ##0 sw_stop |-> ##2 !timer_out)
    else $error("pulse did not end after run cleared");
  AST_PULSE_IRQ: assert property (pulse_cfg && timer_irq |-> ##[0:1] !timer_out)
    else $error("pulse interrupt without trailing edge");
  AST_EXT_TRIG: assert property (s_ext_rise |-> ##[2:6] timer_out)
    else $error("external edge did not start pulse");
  AST_CAP_IRQ: assert property (s_cap_rise |-> ##[2:5] timer_irq)
    else $error("capture edge without interrupt");
  AST_CAP_NONE: assert property ((cap_cfg && ctl[2:0] == 3'h6) [*6] |-> !timer_irq)
    else $error("interrupt with capture disabled and counter stopped");
endmodule
bind ptm_timer ptm_timer_checker u_chk (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ext_clock_pin,
  .capture_input_pin, .timer_out, .timer_out_oe_n, .timer_irq);
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the periodic timer.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_clock_pin = 1'b0;
  logic capture_input_pin = 1'b0;
  logic [ptm_pkg::ADDR_W-1:0] addr = 3'h0;
  logic [ptm_pkg::DATA_W-1:0] wdata = 16'h0000;
  logic [ptm_pkg::DATA_W-1:0] rdata;
  logic timer_out;
  logic timer_out_oe_n;
  logic timer_irq;
  logic [15:0] lf = 16'h0014;
  int err_count = 0;
  int n_checks = 0;
  int irqs = 0;
  int hi = 0;
  ptm_timer uut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ext_clock_pin, .capture_input_pin,
    .timer_out, .timer_out_oe_n, .timer_irq);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Interrupt pulses and high cycles of the output
  always @(posedge clk) begin
    if (timer_irq === 1'b1) irqs <= irqs + 1;
    if (timer_out === 1'b1) hi <= hi + 1;
  end
  // ==========
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_irq(input logic [1:0] io);
    return (io == ptm_pkg::IO_BOTH) ? 16'h0002 : {15'h0000, io != ptm_pkg::IO_NONE};
  endfunction
  function automatic logic cnt_ok(input logic [1:0] clr, input logic [15:0] c);
    if (clr == ptm_pkg::CLR_NONE) return c > 16'h0078;
    if (clr == ptm_pkg::CLR_RISE) return c > 16'h001E && c < 16'h003C;
    return c < 16'h0019;
  endfunction
  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_out(input logic v);
    for (int i = 0; i < 2000 && timer_out !== v; i++) @(posedge clk);
    chk("out_wait", {15'h0000, v}, {15'h0000, timer_out});
    if (timer_out !== v) stop_test();
  endtask
  task automatic irq_gap(output int g);
    int i0;
    i0 = irqs;
    for (int i = 0; i < 3000 && irqs == i0; i++) @(posedge clk);
    for (g = 0; g < 3000 && irqs == i0 + 1; g++) @(posedge clk);
  endtask
  // One pulse, period and clear select set at random to show they are ignored
  task automatic pulse(input logic [9:0] n, input logic ext, output int w, output int q);
    int h0;
    int i0;
    wreg(ptm_pkg::REG_CMPA, {6'h00, n});
    wreg(ptm_pkg::REG_PERIOD, lf & 16'h0007);
    h0 = hi;
    i0 = irqs;
    wreg(ptm_pkg::REG_CTRL, 16'h0016 | (lf & 16'h0020) | {15'h0000, !ext});
    if (ext) begin
      ext_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clock_pin <= 1'b0;
    end
    wait_out(1'b1);
    wait_out(1'b0);
    repeat (3) @(posedge clk);
    w = hi - h0;
    q = irqs - i0;
  endtask
  // ==========
  // Main sequence
  initial begin
    int w[3];
    int q[3];
    int i0;
    int g;
    logic [9:0] n;
    logic [9:0] d;
    logic [15:0] c;
    logic [15:0] v;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rreg(3'(a), v);
      chk("reset_val", 16'h0000, v);
    end
    for (int a = 1; a < 4; a++) begin
      lf = lfsr(lf);
      wreg(3'(a), lf);
      rreg(3'(a), v);
      chk("rw", {6'h00, lf[9:0]}, v);
    end
    wreg(3'h7, 16'hffff);
    rreg(3'h7, v);
    chk("unmapped", 16'h0000, v);
    n = 10'h008 + {5'h00, lf[4:0]};
    d = {6'h00, lf[8:5]} + 10'h001;
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      pulse(k == 0 ? n : n + d, k == 2, w[k], q[k]);
      chk("pulse_irq", 16'h0001, 16'(q[k]));
    end
    chk("pulse_width", {6'h00, d}, 16'(w[1] - w[0]));
    chk("ext_width", 16'(w[1]), 16'(w[2]));
    rreg(ptm_pkg::REG_CTRL, v);
    chk("run_cleared", 16'h0000, {15'h0000, v[0]});
    rreg(ptm_pkg::REG_COUNT, c);
    repeat (20) @(posedge clk);
    rreg(ptm_pkg::REG_COUNT, v);
    chk("count_hold", c, v);
    chk("oe_pulse", 16'h0000, {15'h0000, timer_out_oe_n});
    wreg(ptm_pkg::REG_CMPA, 16'h0200);
    wreg(ptm_pkg::REG_CTRL, 16'h0017);
    wait_out(1'b1);
    repeat (10) @(posedge clk);
    i0 = irqs;
    wreg(ptm_pkg::REG_CTRL, 16'h0016);
    repeat (3) @(posedge clk);
    chk("abort_out", 16'h0000, {15'h0000, timer_out});
    chk("abort_irq", 16'h0000, 16'(irqs - i0));
    wreg(ptm_pkg::REG_CTRL, 16'h0096);
    repeat (3) @(posedge clk);
    chk("pol_idle", 16'h0001, {15'h0000, timer_out});
    wreg(ptm_pkg::REG_PERIOD, 16'h0000);
    for (int m = 0; m < 16; m++) begin
      c = {5'h00, 2'(m >> 2), 4'h0, 2'h1, 2'(m), 1'b0};
      wreg(ptm_pkg::REG_CTRL, c);
      repeat (8) @(posedge clk);
      wreg(ptm_pkg::REG_CTRL, c | 16'h0001);
      repeat (100) @(posedge clk);
      i0 = irqs;
      capture_input_pin <= 1'b1;
      repeat (30) @(posedge clk);
      capture_input_pin <= 1'b0;
      repeat (10) @(posedge clk);
      rreg(ptm_pkg::REG_COUNT, v);
      chk("cap_irq", exp_irq(2'(m)), 16'(irqs - i0));
      chk("cnt_clear", 16'h0001, {15'h0000, cnt_ok(2'(m >> 2), v)});
      if (m == 0 || m == 5) begin
        c = (m == 0) ? 16'h0069 : 16'h0021;
        rreg(m == 0 ? ptm_pkg::REG_CMPA : ptm_pkg::REG_CMPB, v);
        chk("cap_val", 16'h0001, {15'h0000, v + 16'h0008 >= c && v <= c + 16'h0008});
        rreg(ptm_pkg::REG_STATUS, v);
        chk("status", 16'h0002, v & ((m == 0) ? 16'h0006 : 16'h0007));
        wreg(ptm_pkg::REG_STATUS, 16'h0006);
      end
    end
    for (int s = 0; s < 3; s++) begin
      wreg(ptm_pkg::REG_CTRL, 16'h0009 | ((s == 1) ? 16'h0100 : 16'h0000) | ((s == 2) ? 16'h0800 : 16'h0000));
      i0 = irqs;
      ext_clock_pin <= 1'b1;
      repeat (6) @(posedge clk);
      ext_clock_pin <= 1'b0;
      repeat (6) @(posedge clk);
      chk("src_sel", {15'h0000, s != 0}, 16'(irqs - i0));
    end
    wreg(ptm_pkg::REG_CTRL, 16'h000E);
    wreg(ptm_pkg::REG_CTRL, 16'h000F);
    repeat (1000) @(posedge clk);
    rreg(ptm_pkg::REG_COUNT, v);
    chk("near_max", 16'h0001, {15'h0000, v > 16'h03DF});
    repeat (40) @(posedge clk);
    rreg(ptm_pkg::REG_COUNT, v);
    chk("wrapped", 16'h0001, {15'h0000, v < 16'h0040});
    n = 10'h005 + {6'h00, lf[3:0]};
    wreg(ptm_pkg::REG_PERIOD, {6'h00, n});
    irq_gap(g);
    chk("period_gap", {6'h00, n} + 16'h0001, 16'(g));
    chk("oe_capture", 16'h0001, {15'h0000, timer_out_oe_n});
    stop_test();
  end
endmodule
`default_nettype wire
